/* design/onewire_memory_cmd_slots.sv */
// Overview of operation
// R1: Write command stores two bytes at 2, 3
// R2: Bus reset abandons a scratchpad write
// R3: Read command sends bytes 0 through 8
// R4: Reset stops a read; new initialization
// R5: Copy writes only alarm bytes to nonvolatile
// R6: Read slots give 0 while copying, then 1
// R7: Master holds strong pull-up 10 ms after copy
// R8: Convert needs no data, then goes idle
// R9: Read slots give 0 while converting, then 1
// R10: Conversion finishes within 500 ms
// R11: Master holds strong pull-up 500 ms after convert
// R12: Reload alarm bytes on command and power-up
// R13: After reload, read slots give conversion ready
// R14: Power command answers 0 bus, 1 external
// R15: Master write slots: falling edge, 60 us, recovery
// R16: Sample 15 to 60 us after fall
// R17: Master write one releases within 15 us
// R18: Master write zero holds low 60 us
// R19: Read slot: drive bit 15 us, release
// R20: Master read slot starts with 1 us low
// R21: Read slots last 60 us plus recovery
// R22: Master samples within 15 us of start
// R23: Master reset holds line low 480 us
// R24: Wait 15-60 us, presence low 60-240 us
// R25: Bytes travel least significant bit first
// R26: Unknown command: ignore slots until reset
`timescale 1ns/1ns
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,       // Local clock
  input  wire logic             rst,       // Asynchronous reset
  input  wire logic             flush,     // Empties the queue
  input  wire logic             in_valid,  // Write side offers a word
  input  wire logic [WIDTH-1:0] in_data,   // Word to store
  output logic                  in_ready,  // Room for a word
  output logic                  out_valid, // A word is waiting
  output logic      [WIDTH-1:0] out_data,  // Oldest word
  input  wire logic             out_ready  // Read side takes the word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  wire              full;
  wire              empty;
  wire              push;
  wire              pop;

  // Extra pointer bit tells full from empty
  assign full      = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  assign empty     = (wr_r == rd_r);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_r[AW-1:0]];
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;

  // Pointers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else if (flush) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_r + (AW+1)'(push);
      rd_r <= rd_r + (AW+1)'(pop);
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end
endmodule

module onewire_memory_cmd_slots #(
  parameter logic [23:0] RST_LOW_CYC = slot_pkg::RST_LOW_CYC_DEF, // Reset detect length
  parameter logic [23:0] CONV_CYC    = slot_pkg::CONV_CYC_DEF,    // Conversion length
  parameter logic [23:0] COPY_CYC    = slot_pkg::COPY_CYC_DEF     // Nonvolatile copy length
) (
  input  wire logic        clk,                 // 25 MHz local clock
  input  wire logic        rst,                 // Asynchronous, active high
  input  wire logic        dq_in,               // Data line level
  output logic             dq_out,              // Level driven when enabled
  output logic             dq_oe_n,             // Low while pulling the line low
  input  wire logic        ext_power,           // External supply present (pin)
  input  wire logic [15:0] temp_value,          // Result from the sensing path
  input  wire logic [7:0]  scratch_crc,         // Check byte from the CRC unit
  output logic [7:0]       upper_alarm_trigger, // Scratchpad byte 2
  output logic [7:0]       lower_alarm_trigger, // Scratchpad byte 3
  output logic             conv_busy,           // Conversion running
  output logic             copy_busy            // Nonvolatile copy running
);
  logic [2:0]                  dq_sync_r;
  logic [2:0]                  pwr_sync_r;
  logic                        line_r;
  logic                        line_d_r;
  logic                        ext_pwr_r;
  logic [slot_pkg::CNT_W-1:0]  low_cnt_r;
  logic [slot_pkg::CNT_W-1:0]  cnt_r;
  logic [slot_pkg::CNT_W-1:0]  conv_cnt_r;
  logic [slot_pkg::CNT_W-1:0]  copy_cnt_r;
  slot_pkg::link_state_t       link_r;
  slot_pkg::cmd_state_t        cmd_r;
  slot_pkg::stat_sel_t         sel_r;
  slot_pkg::status_t           stat;
  logic                        slot_rd_r;
  logic                        rx_bit_vld_r;
  logic                        rx_bit_r;
  logic                        take_r;
  logic                        bus_reset_r;
  logic [7:0]                  rx_sh_r;
  logic [2:0]                  rx_cnt_r;
  logic                        byte_vld_r;
  logic [7:0]                  temp_lo_r;
  logic [7:0]                  temp_hi_r;
  logic [7:0]                  nv_upper_r;
  logic [7:0]                  nv_lower_r;
  logic                        pu_recall_r;
  logic [3:0]                  byte_idx_r;
  logic [2:0]                  bit_idx_r;
  logic                        wr_second_r;
  logic                        fifo_in_ready;
  logic                        fifo_out_valid;
  logic [7:0]                  fifo_out_data;
  wire                         fall;
  wire                         rst_hit;
  wire                         rd_mode;
  wire                         tx_bit;
  wire                         stat_bit;
  wire  [7:0]                  pad_byte;
  wire                         pop_ready;
  wire                         pop;

  // Scratchpad byte at a given index
  function automatic logic [7:0] pad_sel(input logic [3:0] idx, input logic [7:0] t_lo,
                                          input logic [7:0] t_hi, input logic [7:0] up,
                                          input logic [7:0] lo, input logic [7:0] crc);
    case (idx)
      slot_pkg::IDX_TEMP_LO: pad_sel = t_lo;
      slot_pkg::IDX_TEMP_HI: pad_sel = t_hi;
      slot_pkg::IDX_UPPER:   pad_sel = up;
      slot_pkg::IDX_LOWER:   pad_sel = lo;
      slot_pkg::IDX_CRC:     pad_sel = crc;
      default:               pad_sel = slot_pkg::RSV_BYTE;
    endcase
  endfunction

  // Line and strap pass three flops; a change counts once the last two agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dq_sync_r  <= 3'b111;
      pwr_sync_r <= 3'b000;
      line_r     <= 1'b1;
      line_d_r   <= 1'b1;
      ext_pwr_r  <= 1'b0;
    end else begin
      dq_sync_r  <= {dq_sync_r[1:0], dq_in};
      pwr_sync_r <= {pwr_sync_r[1:0], ext_power};
      line_r     <= (dq_sync_r[1] == dq_sync_r[2]) ? dq_sync_r[2] : line_r;
      line_d_r   <= line_r;
      ext_pwr_r  <= (pwr_sync_r[1] == pwr_sync_r[2]) ? pwr_sync_r[2] : ext_pwr_r;
    end
  end

  assign fall    = line_d_r && !line_r;
  assign rst_hit = !line_r && (low_cnt_r == RST_LOW_CYC - 24'h00_0001);

  // Length of the current low phase; saturates so a stuck line reports once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt_r <= '0;
    end else if (line_r) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != RST_LOW_CYC) begin
      low_cnt_r <= low_cnt_r + 24'h00_0001;
    end
  end

  // Read answer: scratchpad bit or selected status bit
  assign stat     = '{conv_busy: conv_busy, copy_busy: copy_busy, ext_power: ext_pwr_r};
  assign pad_byte = pad_sel(byte_idx_r, temp_lo_r, temp_hi_r, upper_alarm_trigger,
                            lower_alarm_trigger, scratch_crc);
  assign stat_bit = (sel_r == slot_pkg::SEL_COPY) ? !stat.copy_busy :  // [R6]
                    (sel_r == slot_pkg::SEL_CONV) ? !stat.conv_busy :  // [R9] [R13]
                    stat.ext_power;                                    // [R14]
  assign rd_mode  = (cmd_r == slot_pkg::C_RD) || (cmd_r == slot_pkg::C_STAT);
  assign tx_bit   = (cmd_r == slot_pkg::C_RD) ? pad_byte[bit_idx_r] : stat_bit; // [R25]

  // Slot engine; a long low aborts whatever is going on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_r       <= slot_pkg::L_IDLE;
      cnt_r        <= '0;
      dq_oe_n      <= 1'b1;
      dq_out       <= 1'b0;
      slot_rd_r    <= 1'b0;
      rx_bit_vld_r <= 1'b0;
      rx_bit_r     <= 1'b0;
      take_r       <= 1'b0;
      bus_reset_r  <= 1'b0;
    end else begin
      cnt_r        <= cnt_r + 24'h00_0001;
      rx_bit_vld_r <= 1'b0;
      take_r       <= 1'b0;
      bus_reset_r  <= 1'b0;
      if (rst_hit) begin
        link_r      <= slot_pkg::L_RSTW;                  // [R2] [R4]
        dq_oe_n     <= 1'b1;
        bus_reset_r <= 1'b1;
      end else begin
        case (link_r)
          slot_pkg::L_IDLE: begin
            if (fall) begin
              link_r    <= slot_pkg::L_SLOT;
              cnt_r     <= '0;
              slot_rd_r <= rd_mode;
              take_r    <= rd_mode;
              dq_oe_n   <= rd_mode ? tx_bit : 1'b1;       // [R19]
            end
          end
          slot_pkg::L_SLOT: begin
            if (!slot_rd_r && cnt_r == slot_pkg::SAMPLE_CYC) begin
              rx_bit_vld_r <= 1'b1;                       // [R16]
              rx_bit_r     <= line_r;
            end
            if (cnt_r == slot_pkg::DRIVE_CYC) begin
              dq_oe_n <= 1'b1;                            // [R19]
            end
            if (cnt_r >= slot_pkg::SLOT_CYC && line_r) begin
              link_r <= slot_pkg::L_IDLE;
            end
          end
          slot_pkg::L_RSTW: begin
            if (line_r) begin
              link_r <= slot_pkg::L_PWAIT;
              cnt_r  <= '0;
            end
          end
          slot_pkg::L_PWAIT: begin
            if (cnt_r == slot_pkg::PWAIT_CYC) begin
              link_r  <= slot_pkg::L_PRES;                // [R24]
              dq_oe_n <= 1'b0;
              cnt_r   <= '0;
            end
          end
          slot_pkg::L_PRES: begin
            if (cnt_r == slot_pkg::PRES_CYC) begin
              link_r  <= slot_pkg::L_IDLE;                // [R24]
              dq_oe_n <= 1'b1;
            end
          end
          default: begin
            link_r  <= slot_pkg::L_IDLE;
            dq_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // Bits to bytes; a full queue holds the byte and drops bits meanwhile
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_sh_r    <= '0;
      rx_cnt_r   <= '0;
      byte_vld_r <= 1'b0;
    end else if (bus_reset_r) begin
      rx_cnt_r   <= '0;
      byte_vld_r <= 1'b0;
    end else begin
      if (byte_vld_r && fifo_in_ready) begin
        byte_vld_r <= 1'b0;
      end
      if (rx_bit_vld_r && !byte_vld_r) begin
        rx_sh_r  <= {rx_bit_r, rx_sh_r[7:1]};             // [R25]
        rx_cnt_r <= rx_cnt_r + 3'h1;
        if (rx_cnt_r == 3'h7) begin
          byte_vld_r <= 1'b1;
        end
      end
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(slot_pkg::FIFO_DEPTH)) rx_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (bus_reset_r),
    .in_valid  (byte_vld_r),
    .in_data   (rx_sh_r),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (pop_ready)
  );

  // Alarm bytes may not change under a running copy, so writes wait
  assign pop_ready = !((cmd_r == slot_pkg::C_WR) && copy_busy);
  assign pop       = fifo_out_valid && pop_ready;

  // Command layer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_r       <= slot_pkg::C_CMD;
      sel_r       <= slot_pkg::SEL_CONV;
      byte_idx_r  <= '0;
      bit_idx_r   <= '0;
      wr_second_r <= 1'b0;
    end else if (bus_reset_r) begin
      cmd_r <= slot_pkg::C_CMD;                           // [R2] [R4] [R26]
    end else if (cmd_r == slot_pkg::C_RD && take_r) begin
      bit_idx_r <= bit_idx_r + 3'h1;
      if (bit_idx_r == 3'h7) begin
        byte_idx_r <= byte_idx_r + 4'h1;                  // [R3]
        if (byte_idx_r == slot_pkg::IDX_CRC) begin
          cmd_r <= slot_pkg::C_IDLE;
        end
      end
    end else if (pop && cmd_r == slot_pkg::C_CMD) begin
      byte_idx_r  <= '0;
      bit_idx_r   <= '0;
      wr_second_r <= 1'b0;
      case (fifo_out_data)
        slot_pkg::CMD_WR_SCRATCH: cmd_r <= slot_pkg::C_WR;  // [R1]
        slot_pkg::CMD_RD_SCRATCH: cmd_r <= slot_pkg::C_RD;  // [R3]
        slot_pkg::CMD_COPY: begin
          cmd_r <= slot_pkg::C_STAT;
          sel_r <= slot_pkg::SEL_COPY;                    // [R6]
        end
        slot_pkg::CMD_CONVERT, slot_pkg::CMD_RELOAD_NV: begin
          cmd_r <= slot_pkg::C_STAT;                      // [R8]
          sel_r <= slot_pkg::SEL_CONV;                    // [R9] [R13]
        end
        slot_pkg::CMD_RD_POWER: begin
          cmd_r <= slot_pkg::C_STAT;
          sel_r <= slot_pkg::SEL_POWER;                   // [R14]
        end
        default: cmd_r <= slot_pkg::C_IDLE;               // [R26]
      endcase
    end else if (pop && cmd_r == slot_pkg::C_WR) begin
      wr_second_r <= 1'b1;
      if (wr_second_r) begin
        cmd_r <= slot_pkg::C_IDLE;                        // [R1]
      end
    end
  end

  // Alarm bytes: power-up reload, reload command, then master writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upper_alarm_trigger <= slot_pkg::NV_UPPER_RST;
      lower_alarm_trigger <= slot_pkg::NV_LOWER_RST;
      pu_recall_r         <= 1'b1;
    end else begin
      pu_recall_r <= 1'b0;
      if (pu_recall_r || (pop && cmd_r == slot_pkg::C_CMD &&
                          fifo_out_data == slot_pkg::CMD_RELOAD_NV)) begin
        upper_alarm_trigger <= nv_upper_r;                // [R12]
        lower_alarm_trigger <= nv_lower_r;
      end else if (pop && cmd_r == slot_pkg::C_WR && !bus_reset_r) begin
        if (wr_second_r) begin
          lower_alarm_trigger <= fifo_out_data;           // [R1]
        end else begin
          upper_alarm_trigger <= fifo_out_data;           // [R1]
        end
      end
    end
  end

  // Conversion and copy timers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_cnt_r <= '0;
      copy_cnt_r <= '0;
      conv_busy  <= 1'b0;
      copy_busy  <= 1'b0;
      temp_lo_r  <= '0;
      temp_hi_r  <= '0;
      nv_upper_r <= slot_pkg::NV_UPPER_RST;
      nv_lower_r <= slot_pkg::NV_LOWER_RST;
    end else begin
      if (pop && cmd_r == slot_pkg::C_CMD && fifo_out_data == slot_pkg::CMD_CONVERT) begin
        conv_cnt_r <= CONV_CYC;                           // [R10]
        conv_busy  <= 1'b1;
      end else if (conv_cnt_r != '0) begin
        conv_cnt_r <= conv_cnt_r - 24'h00_0001;
        if (conv_cnt_r == 24'h00_0001) begin
          conv_busy <= 1'b0;                              // [R8]
          temp_lo_r <= temp_value[7:0];
          temp_hi_r <= temp_value[15:8];
        end
      end
      if (pop && cmd_r == slot_pkg::C_CMD && fifo_out_data == slot_pkg::CMD_COPY) begin
        copy_cnt_r <= COPY_CYC;
        copy_busy  <= 1'b1;
      end else if (copy_cnt_r != '0) begin
        copy_cnt_r <= copy_cnt_r - 24'h00_0001;
        if (copy_cnt_r == 24'h00_0001) begin
          copy_busy  <= 1'b0;
          nv_upper_r <= upper_alarm_trigger;              // [R5]
          nv_lower_r <= lower_alarm_trigger;              // [R5]
        end
      end
    end
  end
endmodule

`default_nettype wire

/* shared/slot_pkg.sv */
package slot_pkg;

  // Local clock period; every slot time below is derived from it
  localparam int CLK_NS = 40;
  localparam int CNT_W  = 24;

  // Least time: round up, never below one cycle
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time: round down, never below one cycle
  function automatic int floor_cyc(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Slot and reset timing in ns; conversion and copy in ms
  localparam int SAMPLE_NS   = 30_000;  // Inside the 15..60 us window
  localparam int DRIVE_NS    = 15_000;  // Read data valid time
  localparam int SLOT_NS     = 60_000;  // Shortest slot
  localparam int RST_LOW_NS  = 480_000;
  localparam int PWAIT_NS    = 30_000;  // Inside 15..60 us
  localparam int PRES_NS     = 120_000; // Inside 60..240 us
  localparam int CONV_MS     = 500;
  localparam int COPY_MS     = 10;

  localparam logic [CNT_W-1:0] SAMPLE_CYC = CNT_W'(ceil_cyc(SAMPLE_NS));
  localparam logic [CNT_W-1:0] DRIVE_CYC  = CNT_W'(floor_cyc(DRIVE_NS));
  localparam logic [CNT_W-1:0] SLOT_CYC   = CNT_W'(ceil_cyc(SLOT_NS));
  localparam logic [CNT_W-1:0] PWAIT_CYC  = CNT_W'(ceil_cyc(PWAIT_NS));
  localparam logic [CNT_W-1:0] PRES_CYC   = CNT_W'(ceil_cyc(PRES_NS));
  localparam logic [CNT_W-1:0] RST_LOW_CYC_DEF = CNT_W'(ceil_cyc(RST_LOW_NS));
  localparam logic [CNT_W-1:0] CONV_CYC_DEF    = CNT_W'(floor_cyc(CONV_MS * 1_000_000));
  localparam logic [CNT_W-1:0] COPY_CYC_DEF    = CNT_W'(floor_cyc(COPY_MS * 1_000_000));

  // Function command codes
  localparam logic [7:0] CMD_WR_SCRATCH = 8'h4E;
  localparam logic [7:0] CMD_RD_SCRATCH = 8'hBE;
  localparam logic [7:0] CMD_COPY       = 8'h48;
  localparam logic [7:0] CMD_CONVERT    = 8'h44;
  localparam logic [7:0] CMD_RELOAD_NV  = 8'hB8;
  localparam logic [7:0] CMD_RD_POWER   = 8'hB4;

  // Scratchpad layout
  localparam logic [3:0] IDX_TEMP_LO = 4'h0;
  localparam logic [3:0] IDX_TEMP_HI = 4'h1;
  localparam logic [3:0] IDX_UPPER   = 4'h2;
  localparam logic [3:0] IDX_LOWER   = 4'h3;
  localparam logic [3:0] IDX_CRC     = 4'h8;
  localparam logic [7:0] RSV_BYTE    = 8'hFF;
  localparam logic [7:0] NV_UPPER_RST = 8'h00;
  localparam logic [7:0] NV_LOWER_RST = 8'h00;
  localparam int         FIFO_DEPTH  = 16;

  typedef enum logic [4:0] {
    L_IDLE  = 5'b0_0001,
    L_SLOT  = 5'b0_0010,
    L_RSTW  = 5'b0_0100,
    L_PWAIT = 5'b0_1000,
    L_PRES  = 5'b1_0000
  } link_state_t;

  typedef enum logic [4:0] {
    C_IDLE = 5'b0_0001,
    C_CMD  = 5'b0_0010,
    C_WR   = 5'b0_0100,
    C_RD   = 5'b0_1000,
    C_STAT = 5'b1_0000
  } cmd_state_t;

  typedef enum logic [2:0] {
    SEL_COPY  = 3'b001,
    SEL_CONV  = 3'b010,
    SEL_POWER = 3'b100
  } stat_sel_t;

  // Status bits answered in read slots
  typedef struct packed {
    logic conv_busy;
    logic copy_busy;
    logic ext_power;
  } status_t;

endpackage

/* testbench/line_master.sv */
`timescale 1ns/1ns
`default_nettype none
module line_master (
  input  wire logic clk,  // Local clock
  input  wire logic dq,   // Resolved line level
  output logic      m_low // High while master pulls low
);
  initial m_low = 1'b0;

  // Reset pulse, then time the presence answer
  task automatic bus_reset(output int p_at, output int p_len);
    p_at = 0;
    p_len = 0;
    @(negedge clk) m_low = 1'b1;
    repeat (3300) @(negedge clk);
    m_low = 1'b0;
    for (int i = 0; i < 3900; i++) begin
      @(negedge clk);
      if (!dq) begin
        if (p_len == 0) p_at = i;
        p_len++;
      end
    end
  endtask

  // Short low sends a one or reads; long low sends a zero
  task automatic slot(input logic b, output logic r);
    @(negedge clk) m_low = 1'b1;
    repeat (b ? 25 : 1500) @(negedge clk);
    m_low = 1'b0;
    repeat (b ? 225 : 1) @(negedge clk);
    r = dq;
    repeat (b ? 1290 : 39) @(negedge clk);
  endtask

  // Whole byte, least significant bit first
  task automatic xfer(input logic [7:0] w, output logic [7:0] r);
    for (int i = 0; i < 8; i++) slot(w[i], r[i]);
  endtask
endmodule
`default_nettype wire

/* testbench/onewire_memory_cmd_slots_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module onewire_memory_cmd_slots_chk #(
  parameter logic [23:0] RST_LOW_CYC = 24'h00_0C80, // Reset detect length
  parameter logic [23:0] CONV_CYC    = 24'h00_07D0, // Conversion length
  parameter logic [23:0] COPY_CYC    = 24'h00_03E8  // Copy length
) (
  input wire logic        clk,                 // Local clock
  input wire logic        rst,                 // Async reset
  input wire logic        dq_in,               // Line level
  input wire logic        dq_out,              // Driven level
  input wire logic        dq_oe_n,             // Low while pulling
  input wire logic        ext_power,           // Supply strap
  input wire logic [15:0] temp_value,          // Sensor result
  input wire logic [7:0]  scratch_crc,         // Check byte
  input wire logic [7:0]  upper_alarm_trigger, // Byte 2
  input wire logic [7:0]  lower_alarm_trigger, // Byte 3
  input wire logic        conv_busy,           // Converting
  input wire logic        copy_busy            // Copying
);
  logic [23:0] in_run_r;
  logic [23:0] oe_run_r;
  logic [23:0] conv_run_r;
  logic [23:0] copy_run_r;
  logic [23:0] pres_wait_r;

  // Run lengths; a restarted convert keeps counting, and the bounds are exact, so it would fail them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_run_r   <= '0;
      oe_run_r   <= '0;
      conv_run_r <= '0;
      copy_run_r <= '0;
    end else begin
      in_run_r   <= dq_in ? '0 : in_run_r + 24'h00_0001;
      oe_run_r   <= dq_oe_n ? '0 : oe_run_r + 24'h00_0001;
      conv_run_r <= conv_busy ? conv_run_r + 24'h00_0001 : '0;
      copy_run_r <= copy_busy ? copy_run_r + 24'h00_0001 : '0;
    end
  end

  // Cycles since a reset pulse ended; clears to zero once the device pulls the line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pres_wait_r <= '0;
    end else if (dq_in && in_run_r >= RST_LOW_CYC) begin
      pres_wait_r <= 24'h00_0001;
    end else if (!dq_oe_n) begin
      pres_wait_r <= '0;
    end else if (pres_wait_r != '0) begin
      pres_wait_r <= pres_wait_r + 24'h00_0001;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Steps of the initialization answer
  sequence reset_end;
    $rose(dq_in) && (in_run_r >= RST_LOW_CYC);
  endsequence
  sequence held_off;
    dq_oe_n [*8];
  endsequence

  out_zero_a: assert property (!dq_oe_n |-> !dq_out)
    else $error("driven level not low");
  reset_quiet_a: assert property ($fell(rst) |-> dq_oe_n && !conv_busy && !copy_busy)
    else $error("not quiet after reset");
  reload_value_a: assert property ($fell(rst) |-> ##2
    upper_alarm_trigger == slot_pkg::NV_UPPER_RST && lower_alarm_trigger == slot_pkg::NV_LOWER_RST)
    else $error("alarm bytes not reloaded");
  presence_time_a: assert property ($fell(dq_oe_n) && pres_wait_r != '0 |->
    pres_wait_r >= 24'h00_0177 && pres_wait_r <= 24'h00_05DC)
    else $error("presence start out of window");
  presence_quiet_a: assert property (reset_end |-> held_off)
    else $error("pulled too soon after reset");
  pulse_shape_a: assert property ($rose(dq_oe_n) |-> (oe_run_r <= 24'h00_017C) ||
    (oe_run_r >= 24'h00_05DC && oe_run_r <= 24'h00_1770))
    else $error("bad drive pulse length");
  reset_abort_a: assert property (in_run_r > RST_LOW_CYC + 24'h00_0008 |-> dq_oe_n)
    else $error("driving during bus reset");
  conv_bound_a: assert property (conv_run_r <= CONV_CYC)
    else $error("conversion too long");
  copy_bound_a: assert property (copy_run_r <= COPY_CYC)
    else $error("copy too long");
endmodule

bind onewire_memory_cmd_slots onewire_memory_cmd_slots_chk #(
  .RST_LOW_CYC(RST_LOW_CYC), .CONV_CYC(CONV_CYC), .COPY_CYC(COPY_CYC)
) u_chk (
  .clk(clk), .rst(rst), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
  .ext_power(ext_power), .temp_value(temp_value), .scratch_crc(scratch_crc),
  .upper_alarm_trigger(upper_alarm_trigger), .lower_alarm_trigger(lower_alarm_trigger),
  .conv_busy(conv_busy), .copy_busy(copy_busy)
);
`default_nettype wire

/* testbench/onewire_memory_cmd_slots_test.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %0t got %h want %h", $time, (g), (e)); end end
module onewire_memory_cmd_slots_test;
  localparam logic [23:0] CONV_CYC = 24'h00_07D0;
  localparam logic [23:0] COPY_CYC = 24'h00_03E8;
  logic        clk;
  logic        rst;
  logic        ext_power;
  logic [15:0] temp_value;
  logic [7:0]  scratch_crc;
  logic        dq_out;
  logic        dq_oe_n;
  logic        conv_busy;
  logic        copy_busy;
  logic        m_low;
  logic [7:0]  upper_alarm_trigger;
  logic [7:0]  lower_alarm_trigger;
  wire         dq_line;
  int          bad_count;
  int          comparisons;
  int          seed;
  int          p_at;
  int          p_len;
  logic [7:0]  pad [0:8];
  logic [7:0]  exp_q [$];
  logic [7:0]  got;
  logic [7:0]  e;
  logic        r;

  // Pull-up wins unless someone pulls low
  assign dq_line = !(m_low || (!dq_oe_n && !dq_out));

  onewire_memory_cmd_slots #(
    .RST_LOW_CYC(24'h00_0C80), .CONV_CYC(CONV_CYC), .COPY_CYC(COPY_CYC)
  ) u_onewire_memory_cmd_slots (
    .clk(clk), .rst(rst), .dq_in(dq_line), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .ext_power(ext_power), .temp_value(temp_value), .scratch_crc(scratch_crc),
    .upper_alarm_trigger(upper_alarm_trigger), .lower_alarm_trigger(lower_alarm_trigger),
    .conv_busy(conv_busy), .copy_busy(copy_busy)
  );
  line_master u_line_master (.clk(clk), .dq(dq_line), .m_low(m_low));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Verdict and end of run
  task automatic close_out;
    $display("comparisons %0d bad %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Bus reset with presence window checks
  task automatic reset_bus;
    u_line_master.bus_reset(p_at, p_len);
    `CHK(p_at >= 375 && p_at <= 1510, 1'b1)
    `CHK(p_len >= 1500 && p_len <= 6000, 1'b1)
  endtask

  // Watchdog, well past the expected run length
  initial begin
    repeat (200000) @(posedge clk);
    bad_count++;
    close_out();
  end

  // Main sequence
  initial begin
    seed = 24493;
    bad_count = 0;
    comparisons = 0;
    rst = 1'b1;
    ext_power = 1'($random(seed));
    temp_value = 16'($random(seed));
    scratch_crc = 8'($random(seed));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    // Convert, then status slots; parasite power waits it out first
    reset_bus();
    u_line_master.xfer(slot_pkg::CMD_CONVERT, got);
    if (!ext_power) repeat (int'(CONV_CYC) + 50) @(negedge clk);
    for (int i = 0; i < 3; i++) begin
      u_line_master.slot(1'b1, r);
      `CHK(r, !(ext_power && (1290 + 1540 * i < int'(CONV_CYC))))
    end
    `CHK(conv_busy, 1'b0)
    pad[0] = temp_value[7:0];
    pad[1] = temp_value[15:8];
    $display("test convert done");
    // Write both alarm bytes with random values
    reset_bus();
    pad[2] = 8'($random(seed));
    pad[3] = 8'($random(seed));
    u_line_master.xfer(slot_pkg::CMD_WR_SCRATCH, got);
    u_line_master.xfer(pad[2], got);
    u_line_master.xfer(pad[3], got);
    `CHK(upper_alarm_trigger, pad[2])
    `CHK(lower_alarm_trigger, pad[3])
    $display("test write done");
    // Partial scratchpad read, cut short by a reset
    reset_bus();
    u_line_master.xfer(slot_pkg::CMD_RD_SCRATCH, got);
    for (int i = 0; i < 3; i++) exp_q.push_back(pad[i]);
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      u_line_master.xfer(8'hFF, got);
      `CHK(got, e)
    end
    reset_bus();
    `CHK(upper_alarm_trigger, pad[2])
    $display("test read done");
    // Copy after the cut read; parasite power waits it out first
    u_line_master.xfer(slot_pkg::CMD_COPY, got);
    if (!ext_power) repeat (int'(COPY_CYC) + 50) @(negedge clk);
    u_line_master.slot(1'b1, r);
    `CHK(r, !ext_power)
    `CHK(copy_busy, 1'b0)
    `CHK(lower_alarm_trigger, pad[3])
    $display("test copy done");
    close_out();
  end
endmodule
`default_nettype wire
